// >>> core/ochp_blanker.sv
// module: blanking window timer and gated overcurrent sense
`timescale 1ns/1ps
module ochp_blanker
	import ochp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// sense link to the core
	ochp_sense_if.blanker sense
);

	typedef struct packed {
		logic active;
		logic [BLANK_CNT_W-1:0] count;
	} ochp_blank_state_type;

	ochp_blank_state_type state;
	ochp_blank_state_type next_state;

	always_comb begin
		next_state = state;
		if (sense.blankStart) begin
			// threshold forced low, sensing disarmed
			next_state.active = 1'b1; // [R3]
			next_state.count = '0;
		end else if (state.active) begin
			if (sense.switchNodeHigh) begin
				next_state.active = 1'b0; // [R4]
			end else if (state.count == BLANK_CNT_W'(BLANK_CYCLES - 1)) begin
				next_state.active = 1'b0; // [R5]
			end else begin
				next_state.count = state.count + 1'b1; // [R12]
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sense.blankActive = state.active;
	// comparator results are dropped inside the window
	assign sense.senseValid = sense.overCurrent && !state.active; // [R6]

endmodule

// >>> core/ochp_pkg.sv
// package: constants and types for the overcurrent hiccup protection block
package ochp_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int BLANK_TIMEOUT_PS = 125000;
	// longest time rounds down, never below one cycle
	localparam int BLANK_CYCLES_RAW = BLANK_TIMEOUT_PS / CLK_PERIOD_PS;
	localparam int BLANK_CYCLES = (BLANK_CYCLES_RAW < 1) ? 1 : BLANK_CYCLES_RAW;
	localparam int BLANK_CNT_W = 6;

	// ----------------------------------------
	// fault counter
	// ----------------------------------------
	localparam int FAULT_CNT_W = 3;
	localparam logic [FAULT_CNT_W-1:0] FAULT_LIMIT = 3'h7;
	localparam logic [FAULT_CNT_W-1:0] FAULT_CNT_RESET = 3'h0;

	// ----------------------------------------
	// modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		OCHP_IDLE = 3'b001,
		OCHP_RUN = 3'b010,
		OCHP_HICCUP = 3'b100
	} ochp_mode_type;

	localparam int SYNC_BITS = 2;

endpackage

// >>> core/ochp_protect.sv
// module: top of the overcurrent pulse limit and hiccup fault logic
// Functional notes
// [R1] overcurrent while high side on ends the high-side pulse at once
// [R2] a cut pulse keeps high side off until next cycle starts
// [R3] blanking starts right before high-side turn-on, threshold forced low
// [R4] blanking ends early when switch node reaches near supply
// [R5] otherwise blanking ends after about 125 ns timeout
// [R6] comparator ignored during blanking: no cut, no fault count
// [R7] fault counter up per overcurrent cycle, down per clean cycle
// [R8] counter at seven declares fault, both gate drives off
// [R9] fault runs seven soft-start cycles, gates idle, counting down each
// [R10] counter at zero re-enables modulator; persisting fault re-enters
// [R11] soft-start shutdown stops switching and resets pre-bias state
// [R12] blanking timeout is a clock counter; sense inputs synchronised
`timescale 1ns/1ps
module ochp_protect
	import ochp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// modulator side
	input wire logic cycleStart,
	input wire logic pwmDemand,
	input wire logic lowSideDemand,
	input wire logic softStartDone,
	input wire logic softStartShutdown,
	// analog comparators
	input wire logic current_limit_sense,
	input wire logic switchNodeHighRaw,
	// gate drives
	output logic high_side_gate_drive,
	output logic low_side_gate_drive,
	// status
	output logic currentLimitPullDown,
	output logic faultActive,
	output logic modulatorEnable,
	output logic softStartRestart,
	output logic preBiasRelease,
	output logic [FAULT_CNT_W-1:0] faultCount
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		ochp_mode_type mode;
		logic [SYNC_BITS-1:0] ocSync;
		logic [SYNC_BITS-1:0] swSync;
		logic highOn;
		logic lowOn;
		logic pulseCut;
		logic cycleOc;
		logic preBiasDone;
		logic ssRestart;
		logic [FAULT_CNT_W-1:0] count;
	} ochp_state_type;

	ochp_state_type state;
	ochp_state_type next_state;

	ochp_sense_if sense ();

	ochp_blanker blanker (
		.clk(clk),
		.rst(rst),
		.sense(sense)
	);

	// ----------------------------------------
	// sense synchronisers
	// ----------------------------------------
	// first stage feeds only the second stage
	assign sense.overCurrent = state.ocSync[SYNC_BITS-1]; // [R12]
	assign sense.switchNodeHigh = state.swSync[SYNC_BITS-1]; // [R12]

	// ----------------------------------------
	// decoded conditions
	// ----------------------------------------
	logic inRun;
	logic inFault;
	logic ocHit;
	logic startPulse;
	logic counterIdle;
	logic lastRamp;
	logic countUp;

	assign inRun = (state.mode == OCHP_RUN);
	assign inFault = (state.mode == OCHP_HICCUP);
	// an unblanked trip only matters while the high side conducts
	assign ocHit = state.highOn && sense.senseValid; // [R6]
	// demand starts a pulse only where a switching cycle begins
	assign startPulse = inRun && cycleStart && pwmDemand && !softStartShutdown;
	assign counterIdle = (state.count == FAULT_CNT_RESET);
	// the final ramp hands control back to the modulator
	assign lastRamp = (state.count == 3'h1);
	// a trip at the start edge still belongs to the ending cycle
	assign countUp = state.cycleOc || ocHit; // [R7]

	// ----------------------------------------
	// fault counter arithmetic
	// ----------------------------------------
	// never wraps: the limit and zero are caught before these are used
	logic [FAULT_CNT_W-1:0] countInc;
	logic [FAULT_CNT_W-1:0] countDec;

	assign countInc = state.count + 3'h1; // [R7]
	assign countDec = state.count - 3'h1; // [R7]

	// ----------------------------------------
	// low side permission
	// ----------------------------------------
	// low side waits for the first pulse after a pre-biased start
	logic lowPermit;

	assign lowPermit = lowSideDemand && state.preBiasDone;

	// ----------------------------------------
	// blanking request
	// ----------------------------------------
	// armed only when the pulse really starts, never on fault entry
	assign sense.blankStart = startPulse && next_state.highOn; // [R3]

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_state.ocSync = {state.ocSync[SYNC_BITS-2:0], current_limit_sense};
		next_state.swSync = {state.swSync[SYNC_BITS-2:0], switchNodeHighRaw};
		next_state.ssRestart = 1'b0;
		if (softStartShutdown) begin
			// shutdown overrides everything, including a fault in progress
			next_state.mode = OCHP_IDLE; // [R11]
			next_state.highOn = 1'b0;
			next_state.lowOn = 1'b0;
			next_state.pulseCut = 1'b0;
			next_state.cycleOc = 1'b0;
			next_state.preBiasDone = 1'b0; // [R11]
			next_state.count = FAULT_CNT_RESET;
		end else begin
			case (state.mode)
				OCHP_IDLE: begin
					next_state.mode = OCHP_RUN;
				end
				OCHP_RUN: begin
					if (cycleStart) begin
						// close the previous cycle in the fault counter
						if (countUp) begin
							next_state.count = countInc; // [R7]
						end else if (!counterIdle) begin
							next_state.count = countDec; // [R7]
						end
						next_state.cycleOc = 1'b0;
						next_state.pulseCut = 1'b0; // [R2]
					end else if (ocHit) begin
						next_state.cycleOc = 1'b1;
					end
					if (ocHit) begin
						next_state.highOn = 1'b0; // [R1]
						next_state.pulseCut = 1'b1; // [R2]
					end else if (startPulse) begin
						next_state.highOn = 1'b1;
						next_state.preBiasDone = 1'b1;
					end else if (!pwmDemand || state.pulseCut) begin
						next_state.highOn = 1'b0; // [R2]
					end
					next_state.lowOn = lowPermit && !next_state.highOn;
					if (next_state.count == FAULT_LIMIT) begin
						next_state.mode = OCHP_HICCUP; // [R8]
						next_state.highOn = 1'b0; // [R8]
						next_state.lowOn = 1'b0; // [R8]
						next_state.ssRestart = 1'b1; // [R9]
					end
				end
				OCHP_HICCUP: begin
					next_state.highOn = 1'b0; // [R9]
					next_state.lowOn = 1'b0; // [R9]
					next_state.cycleOc = 1'b0;
					next_state.pulseCut = 1'b0;
					if (softStartDone) begin
						next_state.count = countDec; // [R9]
						if (lastRamp) begin
							// restart from scratch, pre-bias guard armed again
							next_state.mode = OCHP_RUN; // [R10]
							next_state.preBiasDone = 1'b0;
						end else begin
							next_state.ssRestart = 1'b1;
						end
					end
				end
				default: begin
					next_state.mode = OCHP_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= '{mode: OCHP_IDLE, count: FAULT_CNT_RESET, default: '0};
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// gate drives
	// ----------------------------------------
	assign high_side_gate_drive = state.highOn;
	assign low_side_gate_drive = state.lowOn;

	// ----------------------------------------
	// status
	// ----------------------------------------
	assign currentLimitPullDown = sense.blankActive; // [R3]
	assign faultActive = inFault;
	assign modulatorEnable = inRun; // [R10]
	assign softStartRestart = state.ssRestart;
	assign preBiasRelease = state.preBiasDone;
	assign faultCount = state.count;

endmodule

// >>> core/ochp_sense_if.sv
// interface: synchronised sense indications and blanking control
`timescale 1ns/1ps
interface ochp_sense_if;
	logic overCurrent;
	logic switchNodeHigh;
	logic blankStart;
	logic blankActive;
	logic senseValid;

	modport blanker (
		input overCurrent,
		input switchNodeHigh,
		input blankStart,
		output blankActive,
		output senseValid
	);
	modport core (
		output blankStart,
		input blankActive,
		input senseValid,
		input switchNodeHigh
	);
endinterface

// >>> verif/ochp_fet_model.sv
// model: external power switches, switch node and current comparator
`timescale 1ns/1ps
module ochp_fet_model #(parameter int RISE = 2, parameter int TRIP = 4) (
	// gate side
	input wire logic clk,
	input wire logic highOn,
	// bench commands
	input wire logic shorted,
	input wire logic slowRise,
	// indications
	output logic switchNodeHighRaw,
	output logic current_limit_sense
);
	int onCycles = 0;
	always @(posedge clk) onCycles <= highOn ? onCycles + 1 : 0;
	// node pulled low once the high side opens, never holds the last level
	assign switchNodeHighRaw = highOn && !slowRise && onCycles >= RISE;
	assign current_limit_sense = highOn && shorted && onCycles >= TRIP;
endmodule

// >>> verif/ochp_protect_monitor.sv
// checker: timing relations at the protection block ports
`timescale 1ns/1ps
module ochp_protect_monitor
	import ochp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cycleStart,
	input wire logic pwmDemand,
	input wire logic softStartDone,
	input wire logic softStartShutdown,
	input wire logic current_limit_sense,
	input wire logic switchNodeHighRaw,
	input wire logic high_side_gate_drive,
	input wire logic low_side_gate_drive,
	input wire logic currentLimitPullDown,
	input wire logic faultActive,
	input wire logic modulatorEnable,
	input wire logic softStartRestart,
	input wire logic preBiasRelease,
	input wire logic [FAULT_CNT_W-1:0] faultCount
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// count six may enter the fault on this start, so it is left out
	AST_START: assert property (cycleStart && pwmDemand && modulatorEnable
		&& !softStartShutdown && faultCount < 3'h6
		|=> high_side_gate_drive && currentLimitPullDown) else $error("no pulse");
	AST_STAY_OFF: assert property (!cycleStart && !high_side_gate_drive
		|=> !high_side_gate_drive) else $error("early pulse");
	AST_CUT: assert property ($past(current_limit_sense, 2) && high_side_gate_drive
		&& !currentLimitPullDown && !cycleStart |=> !high_side_gate_drive) else $error("no cut");
	AST_BLANK_TIMEOUT: assert property ($rose(currentLimitPullDown)
		|-> ##[24:26] !currentLimitPullDown) else $error("blank long");
	AST_BLANK_EARLY: assert property (currentLimitPullDown && switchNodeHighRaw
		|-> ##[1:4] !currentLimitPullDown) else $error("blank not ended");
	AST_BLANK_HOLD: assert property (currentLimitPullDown && high_side_gate_drive
		&& pwmDemand && !cycleStart && !softStartShutdown
		|=> high_side_gate_drive) else $error("cut in blank");
	AST_FAULT_ENTRY: assert property (faultCount == FAULT_LIMIT
		|-> ##[0:1] faultActive) else $error("no fault");
	AST_FAULT_OFF: assert property (faultActive && $past(faultActive)
		|-> !high_side_gate_drive && !low_side_gate_drive) else $error("gate in fault");
	AST_FAULT_DEC: assert property (faultActive && softStartDone && faultCount != 3'h0
		&& !softStartShutdown
		|=> faultCount == $past(faultCount) - 3'h1) else $error("no decrement");
	AST_FAULT_RAMP: assert property ($rose(faultActive)
		|-> softStartRestart && !currentLimitPullDown) else $error("no ramp request");
	AST_RESTART: assert property ($fell(faultActive) && !$past(softStartShutdown)
		|-> modulatorEnable && faultCount == 3'h0) else $error("bad restart");
	AST_SHUT: assert property (softStartShutdown
		|=> !high_side_gate_drive && !preBiasRelease && faultCount == 3'h0) else $error("shut");
endmodule
bind ochp_protect ochp_protect_monitor i_mon (.*);

// >>> verif/test_overcurrent_hiccup_protection.sv
// testbench: pulse limit, blanking and hiccup scenarios
`timescale 1ns/1ps
module test_overcurrent_hiccup_protection;
	import ochp_pkg::*;
	typedef struct {logic sh; logic slow; logic cut; logic tmo;} ochp_row_type;
	ochp_row_type rows[4] = '{'{0, 0, 0, 0}, '{0, 1, 0, 1}, '{1, 0, 1, 0}, '{1, 1, 1, 1}};
	logic clk = 0, rst = 1, cycleStart = 0, pwmDemand = 0, softStartDone = 0, shutdown = 0;
	logic shorted = 0, slowRise = 0, snRaw, oc, high, low, pullDown, fault, modEn, preBias;
	logic [FAULT_CNT_W-1:0] faultCount;
	int mismatches = 0, check_count = 0, blankLen, hiLen;
	always #2.5 clk = ~clk;
	ochp_fet_model i_fet(.clk, .highOn(high), .shorted, .slowRise,
		.switchNodeHighRaw(snRaw), .current_limit_sense(oc));
	ochp_protect i_dut(.clk, .rst, .cycleStart, .pwmDemand, .lowSideDemand(1'b1),
		.softStartDone, .softStartShutdown(shutdown), .current_limit_sense(oc),
		.switchNodeHighRaw(snRaw), .high_side_gate_drive(high), .low_side_gate_drive(low),
		.currentLimitPullDown(pullDown), .faultActive(fault), .modulatorEnable(modEn),
		.softStartRestart(), .preBiasRelease(preBias), .faultCount);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// one switching cycle with demand held; high time and blank time counted
	task automatic pulse(input logic sh, input logic slow);
		@(posedge clk);
		shorted <= sh;
		slowRise <= slow;
		cycleStart <= 1;
		pwmDemand <= 1;
		@(posedge clk);
		cycleStart <= 0;
		blankLen = 0;
		hiLen = 0;
		repeat (40) begin
			#1;
			blankLen += pullDown;
			hiLen += high;
			@(posedge clk);
		end
		pwmDemand <= 0;
		repeat (2) @(posedge clk);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		foreach (rows[i]) begin
			pulse(rows[i].sh, rows[i].slow);
			check(hiLen < 40, rows[i].cut);
			check(blankLen == 25, rows[i].tmo);
			check(hiLen > blankLen, 1'b1);
			$display("row %0d done", i);
		end
		#1 check(faultCount, 3'h1);
		for (int i = 0; i < 10 && !fault; i++) pulse(1, 0);
		check(fault, 1'b1);
		check(faultCount, FAULT_LIMIT);
		check(high | low, 1'b0);
		repeat (7) begin
			check(modEn, 1'b0);
			@(posedge clk) softStartDone <= 1;
			@(posedge clk) softStartDone <= 0;
			repeat (3) @(posedge clk);
		end
		#1 check({fault, modEn, faultCount}, 5'h08);
		pulse(0, 0);
		check(hiLen == 40 && preBias, 1'b1);
		$display("hiccup done");
		@(posedge clk) shutdown <= 1;
		repeat (2) @(posedge clk);
		#1 check({high, preBias, faultCount}, 5'h00);
		@(posedge clk) shutdown <= 0;
		repeat (2) @(posedge clk);
		cycleStart <= 1;
		pwmDemand <= 1;
		@(posedge clk) cycleStart <= 0;
		@(posedge clk) rst <= 1;
		// reset lands mid pulse: gates, pull-down, modulator enable, pre-bias and fault count must clear at once
		#1 check({high, low, pullDown, modEn, preBias, faultCount}, 8'h00);
		$display("reset done");
		summarize();
	end
endmodule
